// file: include/ssa_consts.svh
// Constants for the stereo serial audio input port and its source
// Overview of operation
// R1: Samples are twos complement, MSB first
// R2: Left channel field precedes right channel field
// R3: Mode input selects LJ, I2S, RJ, DSP
// R4: Non-RJ modes take up to 24 bits, discard extras
// R5: RJ word length 16/20/24 from bits 1:0
// R6: Word length resets to 24 bits
// R7: Source sends exactly 64 bit clocks per RJ frame
// R8: LJ: sync high left, rising-edge sampling
// R9: LJ: MSB in first slot after transition
// R10: I2S: sync low left, rising-edge sampling
// R11: I2S: MSB one bit clock after transition
// R12: RJ: sync high left, data delayed 8/12/16
// R13: DSP: sync pulses high before each MSB
// R14: DSP: falling-edge sampling, up to 24 bits
// R15: DSP: first pulse carries left, alternation kept
// R16: Sync at sample rate, DSP at twice
// R17: Bit clock 64 times sync rate; in DSP mode the source gives 32 bit clocks per sync pulse
// R18: Words left aligned, zero filled, parallel out
`ifndef SSA_CONSTS_SVH
`define SSA_CONSTS_SVH

`define SSA_MAX_BITS       24
`define SSA_SLOTS_FRAME    64
`define SSA_WL_24          2'h0
`define SSA_WL_20          2'h1
`define SSA_WL_16          2'h2
`define SSA_WL_RESET       2'h0
`define SSA_WL_FIELD_MSB   1
`define SSA_WL_FIELD_LSB   0
`define SSA_RJ_DELAY_24    6'h08
`define SSA_RJ_DELAY_20    6'h0c
`define SSA_RJ_DELAY_16    6'h10
`define SSA_CLK_PERIOD_NS  100
`define SSA_BCLK_PERIOD_NS 800
`define SSA_BCLK_HALF      (`SSA_BCLK_PERIOD_NS / (2 * `SSA_CLK_PERIOD_NS))

`endif

// file: include/ssa_pkg.sv
// Types shared by both ends of the serial audio link
package ssa_pkg;

  typedef enum logic [1:0] {
    SSA_MODE_LJ,
    SSA_MODE_I2S,
    SSA_MODE_RJ,
    SSA_MODE_DSP
  } ssa_mode_t;

  typedef logic [23:0] ssa_word_t;

endpackage

// file: include/ssa_if.sv
// Three-wire serial audio link between source and port
`timescale 1ns/1ps
`default_nettype none

interface ssa_if;
  logic frame_sync;
  logic bit_clk;
  logic ser_data;

  modport src (
    output frame_sync,
    output bit_clk,
    output ser_data
  );

  modport dev (
    input frame_sync,
    input bit_clk,
    input ser_data
  );
endinterface

`default_nettype wire

// file: rtl/ssa_src_end.sv
// Audio source end: makes bit clock, frame sync and serial data
`timescale 1ns/1ps
`default_nettype none
`include "ssa_consts.svh"

module ssa_src_end #(
  parameter int HALF = `SSA_BCLK_HALF
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  ssa_if.src                     link,
  input  wire ssa_pkg::ssa_mode_t i_mode,
  input  wire logic [1:0]        i_word_len,
  input  wire ssa_pkg::ssa_word_t i_left,
  input  wire ssa_pkg::ssa_word_t i_right,
  output logic                   o_taken
);

  localparam int HC_W = (HALF > 1) ? $clog2(HALF) : 1;

  logic [HC_W-1:0]    hc, next_hc;
  logic               bclk, next_bclk;
  logic               fs, next_fs;
  logic               sd, next_sd;
  logic [5:0]         slot, next_slot;
  ssa_pkg::ssa_mode_t mode_q, next_mode_q;
  logic [1:0]         wl_q, next_wl_q;
  ssa_pkg::ssa_word_t left_q, next_left_q;
  ssa_pkg::ssa_word_t right_q, next_right_q;
  logic               taken, next_taken;

  ////////////////////////////////////////////////////////////////////////////
  // Divider, slot sequencing and bit launch
  always_comb begin
    logic               tog;
    logic               launch;
    logic [4:0]         k;
    logic [5:0]         d;
    ssa_pkg::ssa_word_t w;
    ssa_pkg::ssa_mode_t lmode;
    tog = 1'b0;
    launch = 1'b0;
    k = 5'h00;
    d = `SSA_RJ_DELAY_24;
    w = '0;
    // Slot 0 already launches on the edge of the mode it loads
    lmode = (slot == 6'h3f) ? i_mode : mode_q;
    next_hc = hc + HC_W'(1);
    next_bclk = bclk;
    next_fs = fs;
    next_sd = sd;
    next_slot = slot;
    next_mode_q = mode_q;
    next_wl_q = wl_q;
    next_left_q = left_q;
    next_right_q = right_q;
    next_taken = 1'b0;
    tog = (hc == HC_W'(HALF - 1));
    if (tog) begin
      next_hc = '0;
      next_bclk = ~bclk;
    end
    // Launch opposite the sampling edge
    launch = tog && ((lmode == ssa_pkg::SSA_MODE_DSP) ? ~bclk : bclk); // [R8] [R14]
    if (launch) begin
      next_slot = slot + 6'h01; // [R7] [R17]
      if (next_slot == 6'h00) begin
        next_mode_q = i_mode;
        next_wl_q = i_word_len;
        next_left_q = i_left;
        next_right_q = i_right;
        next_taken = 1'b1;
      end
      k = next_slot[4:0];
      w = next_slot[5] ? next_right_q : next_left_q; // [R2]
      case (next_wl_q)
        `SSA_WL_20: d = `SSA_RJ_DELAY_20;
        `SSA_WL_16: d = `SSA_RJ_DELAY_16;
        default:    d = `SSA_RJ_DELAY_24;
      endcase
      case (next_mode_q)
        ssa_pkg::SSA_MODE_LJ: begin
          next_fs = ~next_slot[5]; // [R8]
          next_sd = (k < 5'd24) ? w[5'd23 - k] : 1'b0; // [R9] [R1]
        end
        ssa_pkg::SSA_MODE_I2S: begin
          next_fs = next_slot[5]; // [R10]
          next_sd = (k >= 5'd1 && k <= 5'd24) ? w[5'd24 - k] : 1'b0; // [R11]
        end
        ssa_pkg::SSA_MODE_RJ: begin
          next_fs = ~next_slot[5]; // [R12]
          next_sd = ({1'b0, k} >= d) ? w[5'd23 - (k - d[4:0])] : 1'b0; // [R12]
        end
        default: begin
          next_fs = (k == 5'd0); // [R13] [R15] [R16]
          next_sd = (k >= 5'd1 && k <= 5'd24) ? w[5'd24 - k] : 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hc <= '0;
      bclk <= 1'b1;
      fs <= 1'b0;
      sd <= 1'b0;
      slot <= 6'h3f;
      mode_q <= ssa_pkg::SSA_MODE_LJ;
      wl_q <= `SSA_WL_RESET;
      left_q <= '0;
      right_q <= '0;
      taken <= 1'b0;
    end else begin
      hc <= next_hc;
      bclk <= next_bclk;
      fs <= next_fs;
      sd <= next_sd;
      slot <= next_slot;
      mode_q <= next_mode_q;
      wl_q <= next_wl_q;
      left_q <= next_left_q;
      right_q <= next_right_q;
      taken <= next_taken;
    end
  end

  assign link.bit_clk = bclk;
  assign link.frame_sync = fs;
  assign link.ser_data = sd;
  assign o_taken = taken;

endmodule

`default_nettype wire

// file: rtl/ssa_dev_end.sv
// Serial audio input port: deserialises left and right samples
`timescale 1ns/1ps
`default_nettype none
`include "ssa_consts.svh"

module ssa_dev_end (
  input  wire logic               i_core_clk,
  input  wire logic               i_rstn,
  ssa_if.dev                      link,
  input  wire ssa_pkg::ssa_mode_t i_mode,
  input  wire logic [1:0]         i_word_len,
  output ssa_pkg::ssa_word_t      o_sample,
  output logic                    o_left,
  output logic                    o_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] bc_sy;
  logic [1:0] fs_sy;
  logic [1:0] sd_sy;
  logic [2:0] next_bc_sy;
  logic [1:0] next_fs_sy;
  logic [1:0] next_sd_sy;

  always_comb begin
    next_bc_sy = {bc_sy[1:0], link.bit_clk};
    next_fs_sy = {fs_sy[0], link.frame_sync};
    next_sd_sy = {sd_sy[0], link.ser_data};
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bc_sy <= 3'h7;
      fs_sy <= 2'h0;
      sd_sy <= 2'h0;
    end else begin
      bc_sy <= next_bc_sy;
      fs_sy <= next_fs_sy;
      sd_sy <= next_sd_sy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control latches
  ssa_pkg::ssa_mode_t mode_q, next_mode_q;
  logic [1:0]         wl_q, next_wl_q;

  always_comb begin
    next_mode_q = i_mode; // [R3]
    next_wl_q = i_word_len[`SSA_WL_FIELD_MSB:`SSA_WL_FIELD_LSB]; // [R5]
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_q <= ssa_pkg::SSA_MODE_LJ;
      wl_q <= `SSA_WL_RESET; // [R6]
    end else begin
      mode_q <= next_mode_q;
      wl_q <= next_wl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Framing and shift assembly
  logic               fs_prev, next_fs_prev;
  logic               synced, next_synced;
  logic               cur_left, next_cur_left;
  logic               dsp_left, next_dsp_left;
  logic               cap_en, next_cap_en;
  logic [5:0]         slot, next_slot;
  logic [4:0]         nbits, next_nbits;
  ssa_pkg::ssa_word_t acc, next_acc;
  ssa_pkg::ssa_word_t sample, next_sample;
  logic               left_o, next_left_o;
  logic               valid, next_valid;

  always_comb begin
    logic       rise;
    logic       fall;
    logic       edge_hit;
    logic       bnd;
    logic       start;
    logic       take;
    logic       fs_s;
    logic [5:0] d;
    rise = bc_sy[1] & ~bc_sy[2];
    fall = ~bc_sy[1] & bc_sy[2];
    edge_hit = 1'b0;
    bnd = 1'b0;
    start = 1'b0;
    take = 1'b0;
    fs_s = fs_sy[1];
    d = `SSA_RJ_DELAY_24;
    next_fs_prev = fs_prev;
    next_synced = synced;
    next_cur_left = cur_left;
    next_dsp_left = dsp_left;
    next_cap_en = cap_en;
    next_slot = slot;
    next_nbits = nbits;
    next_acc = acc;
    next_sample = sample;
    next_left_o = left_o;
    next_valid = 1'b0;
    case (wl_q)
      `SSA_WL_20: d = `SSA_RJ_DELAY_20;
      `SSA_WL_16: d = `SSA_RJ_DELAY_16;
      default:    d = `SSA_RJ_DELAY_24; // [R5] [R6]
    endcase
    edge_hit = (mode_q == ssa_pkg::SSA_MODE_DSP) ? fall : rise; // [R8] [R10] [R14]
    if (edge_hit) begin
      next_fs_prev = fs_s;
      if (mode_q == ssa_pkg::SSA_MODE_DSP) begin
        bnd = fs_s & ~fs_prev; // [R13]
        start = ~fs_s & fs_prev;
      end else begin
        bnd = fs_s ^ fs_prev;
      end
      // Hand over the finished word at each boundary after the first, if any bits were taken
      if (bnd && synced && nbits != 5'd0) begin
        next_sample = acc; // [R18]
        next_left_o = cur_left; // [R2]
        next_valid = 1'b1;
      end
      if (bnd) begin
        next_acc = '0; // [R18]
        next_nbits = 5'd0;
        next_synced = 1'b1;
        next_slot = 6'h00;
        if (mode_q == ssa_pkg::SSA_MODE_DSP) begin
          next_cur_left = dsp_left; // [R15]
          next_dsp_left = ~dsp_left;
          next_cap_en = 1'b0;
        end else if (mode_q == ssa_pkg::SSA_MODE_I2S) begin
          next_cur_left = ~fs_s; // [R10]
        end else begin
          next_cur_left = fs_s; // [R8] [R12]
        end
      end else if (start) begin
        next_slot = 6'h00;
        next_cap_en = synced; // [R13]
      end else if (slot != 6'h3f) begin
        next_slot = slot + 6'h01;
      end
      case (mode_q)
        ssa_pkg::SSA_MODE_LJ:  take = 1'b1; // [R9]
        ssa_pkg::SSA_MODE_I2S: take = (next_slot >= 6'h01); // [R11]
        ssa_pkg::SSA_MODE_RJ:  take = (next_slot >= d); // [R12]
        default:               take = next_cap_en & ~fs_s; // [R14]
      endcase
      // Bits beyond the limit are dropped silently
      if (take && next_synced && next_nbits < 5'(`SSA_MAX_BITS)) begin // [R4]
        next_acc[5'd23 - next_nbits] = sd_sy[1]; // [R1]
        next_nbits = next_nbits + 5'd1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fs_prev <= 1'b0;
      synced <= 1'b0;
      cur_left <= 1'b1;
      dsp_left <= 1'b1;
      cap_en <= 1'b0;
      slot <= 6'h00;
      nbits <= 5'd0;
      acc <= '0;
      sample <= '0;
      left_o <= 1'b0;
      valid <= 1'b0;
    end else begin
      fs_prev <= next_fs_prev;
      synced <= next_synced;
      cur_left <= next_cur_left;
      dsp_left <= next_dsp_left;
      cap_en <= next_cap_en;
      slot <= next_slot;
      nbits <= next_nbits;
      acc <= next_acc;
      sample <= next_sample;
      left_o <= next_left_o;
      valid <= next_valid;
    end
  end

  assign o_sample = sample;
  assign o_left = left_o;
  assign o_valid = valid;

endmodule

`default_nettype wire

// file: bench/ssa_monitor.sv
// Link checker for the serial audio link
`timescale 1ns/1ps
`default_nettype none

module ssa_monitor #(
  parameter int HALF = 4
) (
  input wire logic               i_core_clk,
  input wire logic               i_rstn,
  input wire logic               frame_sync,
  input wire logic               bit_clk,
  input wire logic               ser_data,
  input wire ssa_pkg::ssa_mode_t i_mode
);
  logic [3:0] hold;
  logic [3:0] next_hold;
  logic [6:0] run;
  logic [6:0] next_run;
  logic       bc_q;
  logic       fs_q;
  logic       sd_q;
  logic       armed;
  logic       bseen;
  logic       dsp;
  logic       chg;
  logic       fchg;
  logic       dchg;
  logic       launch;

  ////////////////////////////////////////////////////////////////////////
  // Edge and run counters
  assign dsp = (i_mode == ssa_pkg::SSA_MODE_DSP);
  assign chg = (bit_clk != bc_q);
  assign fchg = (frame_sync != fs_q);
  assign dchg = (ser_data != sd_q);
  assign launch = chg && (bit_clk == dsp);

  always_comb begin
    next_hold = chg ? 4'h0 : hold + 4'h1;
    next_run = fchg ? 7'h01 : run + {6'h00, launch};
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hold <= 4'h0;
      run <= 7'h00;
      bc_q <= 1'b1;
      fs_q <= 1'b0;
      sd_q <= 1'b0;
      armed <= 1'b0;
      bseen <= 1'b0;
    end else begin
      hold <= next_hold;
      run <= next_run;
      bc_q <= bit_clk;
      fs_q <= frame_sync;
      sd_q <= ser_data;
      armed <= armed | fchg;
      bseen <= bseen | chg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);

  AST_BCLK_HALF: assert property (chg && bseen |-> hold == HALF - 1)
    else $error("bit clock half period wrong");
  AST_BCLK_STALL: assert property (bseen |-> hold <= HALF)
    else $error("bit clock stalled");
  AST_FS_EDGE: assert property (fchg |-> launch)
    else $error("frame sync moved off launch edge");
  AST_DATA_EDGE: assert property (dchg |-> launch)
    else $error("data moved off launch edge");
  AST_RUN_FULL: assert property (fchg && armed && !dsp |-> run == 7'd32)
    else $error("channel not 32 bit clocks");
  AST_DSP_PULSE: assert property (fchg && armed && dsp && !frame_sync |-> run == 7'd1)
    else $error("sync pulse not one bit clock");
  AST_DSP_GAP: assert property (fchg && armed && dsp && frame_sync |-> run == 7'd31)
    else $error("sync pulse spacing wrong");
  AST_RUN_MAX: assert property (armed |-> run <= (dsp ? 7'd31 : 7'd32))
    else $error("frame sync stuck");

  cover property (fchg && armed && dsp);
  cover property (fchg && armed && i_mode == ssa_pkg::SSA_MODE_RJ);
  cover property (fchg && armed && i_mode == ssa_pkg::SSA_MODE_I2S);
endmodule

`default_nettype wire

// file: bench/stereo_serial_audio_input_port_bench.sv
// Testbench for both ends of the serial audio link
`timescale 1ns/1ps
`default_nettype none

module stereo_serial_audio_input_port_bench;
  localparam int HALF = 2;
  logic               i_core_clk;
  logic               i_rstn;
  ssa_pkg::ssa_mode_t i_mode;
  logic [1:0]         i_word_len;
  ssa_pkg::ssa_word_t i_left;
  ssa_pkg::ssa_word_t i_right;
  ssa_pkg::ssa_word_t o_sample;
  ssa_pkg::ssa_word_t b_sample;
  ssa_pkg::ssa_word_t b_word [2];
  logic               o_left;
  logic               o_valid;
  logic               b_left;
  logic               b_valid;
  logic               o_taken;
  int                 taken_n = 0;
  int                 failures;
  int                 compares;
  int                 cycles = 0;

  ssa_if link_a ();
  ssa_if link_b ();

  ssa_src_end #(.HALF(HALF)) ssa_src_end_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .link(link_a), .i_mode(i_mode), .i_word_len(i_word_len), .i_left(i_left),
    .i_right(i_right), .o_taken(o_taken));
  ssa_dev_end ssa_dev_end_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .link(link_a),
    .i_mode(i_mode), .i_word_len(i_word_len), .o_sample(o_sample), .o_left(o_left),
    .o_valid(o_valid));
  ssa_dev_end ssa_dev_end_b_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .link(link_b),
    .i_mode(i_mode), .i_word_len(i_word_len), .o_sample(b_sample), .o_left(b_left),
    .o_valid(b_valid));
  ssa_monitor #(.HALF(HALF)) ssa_monitor_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .frame_sync(link_a.frame_sync), .bit_clk(link_a.bit_clk), .ser_data(link_a.ser_data),
    .i_mode(i_mode));

  ////////////////////////////////////////////////////////////////////////
  // Clock, timeout, capture
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  always @(posedge i_core_clk) begin
    if (b_valid === 1'b1) begin
      b_word[b_left] <= b_sample;
    end
    if (o_taken === 1'b1) begin
      taken_n++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task check(input string what, input ssa_pkg::ssa_word_t seen, input ssa_pkg::ssa_word_t exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task do_reset();
    i_rstn = 1'b0;
    tick(16);
    i_rstn = 1'b1;
  endtask

  task get_word();
    for (int n = 0; n < 1000; n++) begin
      tick(1);
      if (o_valid === 1'b1) return;
    end
    check("o_valid", 24'h0, 24'h1);
  endtask

  task run_case(input ssa_pkg::ssa_mode_t m, input logic [1:0] wl,
                input ssa_pkg::ssa_word_t l, input ssa_pkg::ssa_word_t r);
    ssa_pkg::ssa_word_t mask;
    int                 t0;
    mask = 24'hffffff;
    if (m == ssa_pkg::SSA_MODE_RJ && wl == 2'h1) mask = 24'hfffff0;
    if (m == ssa_pkg::SSA_MODE_RJ && wl == 2'h2) mask = 24'hffff00;
    i_mode = m;
    i_word_len = wl;
    i_left = l;
    i_right = r;
    do_reset();
    get_word();
    if (o_left !== 1'b1) get_word();
    if (o_left !== 1'b1) get_word();
    check("left word", o_sample, l & mask);
    t0 = taken_n;
    get_word();
    check("right flag", {23'h0, o_left}, 24'h0);
    check("right word", o_sample, r & mask);
    check("frames taken", 24'(taken_n - t0), 24'h1);
  endtask

  task lb_bit(input logic fs, input logic d);
    link_b.bit_clk = 1'b0;
    link_b.frame_sync = fs;
    link_b.ser_data = d;
    tick(HALF);
    link_b.bit_clk = 1'b1;
    tick(HALF);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task test_framing();
    run_case(ssa_pkg::SSA_MODE_LJ, 2'h2, 24'ha5c3e1, 24'h5a3c1e);
    run_case(ssa_pkg::SSA_MODE_I2S, 2'h0, 24'h80000f, 24'h7ffff0);
    run_case(ssa_pkg::SSA_MODE_DSP, 2'h0, 24'hc0ffe7, 24'h123456);
    $display("framing test done");
  endtask

  task test_rj();
    for (int w = 0; w < 4; w++) begin
      run_case(ssa_pkg::SSA_MODE_RJ, w[1:0], 24'h9d2b7f, 24'h31c4e6);
    end
    $display("right justified test done");
  endtask

  task test_extra_bits();
    ssa_pkg::ssa_word_t v;
    i_mode = ssa_pkg::SSA_MODE_LJ;
    i_word_len = 2'h0;
    do_reset();
    for (int c = 0; c < 3; c++) begin
      v = (c == 1) ? 24'he13579 : 24'h2468ac;
      for (int k = 0; k < 28; k++) begin
        lb_bit(c != 1, (k < 24) ? v[23 - k] : 1'b1);
      end
    end
    tick(8);
    check("long left", b_word[1], 24'h2468ac);
    check("long right", b_word[0], 24'he13579);
    $display("extra bits test done");
  endtask

  task wrap_up();
    $display("Comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    failures = 0;
    compares = 0;
    i_rstn = 1'b0;
    i_mode = ssa_pkg::SSA_MODE_LJ;
    i_word_len = 2'h0;
    i_left = 24'h0;
    i_right = 24'h0;
    link_b.bit_clk = 1'b1;
    link_b.frame_sync = 1'b0;
    link_b.ser_data = 1'b0;
    test_framing();
    test_rj();
    test_extra_bits();
    wrap_up();
  end
endmodule

`default_nettype wire
